// ===== src/ddr_sram_dual_port_pins.sv
// Purpose: Pin behaviour of a two-word burst DDR SRAM, split ports
// Assumes: Input clocks are slow and sampled by mclk
// Notes:   Wide variant only; one cycle means one input clock period
`timescale 1ns/10ps
`default_nettype none
`include "ddr_pins_map.svh"
module ddr_sram_dual_port_pins
  import ddr_pins_pkg::*;
(
  input  wire logic  mclk,
  input  wire logic  rst_n,
  input  wire logic  in_clk,
  input  wire logic  in_clk_n,
  input  wire logic  read_port_select_n,
  input  wire logic  write_port_select_n,
  input  wire mask_t byte_lane_write_mask_n,
  input  wire addr_t addr,
  input  wire word_t write_data,
  input  wire logic  delay_loop_disable_n,
  output var  word_t read_data_out,
  output var  logic  read_data_oe,
  output var  logic  read_output_valid,
  output var  logic  echo_timing_out,
  output var  logic  echo_timing_out_n
);
  logic [`PIN_W-1:0] pins_s;
  logic              k_s;
  logic              kb_s;
  logic              rps_s;
  logic              wps_s;
  logic              dll_s;
  mask_t             mask_s;
  addr_t             addr_s;
  word_t             d_s;

  core_t             st_reg;
  core_t             st_next;

  logic              k_rise;
  logic              kb_rise;
  rd_slot_t          launch;
  logic              mem_wr_en;
  word_t             rd_word0;
  word_t             rd_word1;

  // All pins share one delay so data stays aligned with clock edges
  pin_sync #(
    .W (`PIN_W)
  ) u_pin_sync (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .pins   ({in_clk, in_clk_n, read_port_select_n, write_port_select_n,
              delay_loop_disable_n, byte_lane_write_mask_n, addr,
              write_data}),
    .synced (pins_s)
  );

  assign {k_s, kb_s, rps_s, wps_s, dll_s, mask_s, addr_s, d_s} = pins_s;

  assign k_rise  = k_s & ~st_reg.k_prev;
  assign kb_rise = kb_s & ~st_reg.kb_prev;

  // Delay loop pin is static; a change mid read may drop one burst
  assign launch = dll_s ? st_reg.rd_pipe[`RD_LAT_DLL-1]
                        : st_reg.rd_pipe[`RD_LAT_NODLL-1];

  // Write address and second beat come with the complement rise
  assign mem_wr_en = kb_rise & (st_reg.wr_state == WR_BEAT1);

  sram_lane_store u_store (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .wr_en    (mem_wr_en),
    .wr_addr  (addr_s),
    .wr_word0 (st_reg.wr_beat0),
    .wr_bits0 (lane_bits(st_reg.wr_mask0)),
    .wr_word1 (d_s),
    .wr_bits1 (lane_bits(mask_s)),
    .rd_addr  (launch.addr),
    .rd_word0 (rd_word0),
    .rd_word1 (rd_word1)
  );

  always_comb begin
    st_next         = st_reg;
    st_next.k_prev  = k_s;
    st_next.kb_prev = kb_s;
    st_next.echo    = k_s;
    st_next.echo_n  = kb_s;
    if (k_rise) begin
      if (launch.vld) begin
        st_next.q          = rd_word0;
        st_next.q_beat1    = rd_word1;
        st_next.beat1_pend = 1'b1;
        st_next.q_oe       = 1'b1;
        st_next.q_vld      = 1'b1;
      end else begin
        st_next.q_oe       = 1'b0;
        st_next.q_vld      = 1'b0;
        st_next.beat1_pend = 1'b0;
      end
      st_next.rd_pipe[1]     = st_reg.rd_pipe[0];
      st_next.rd_pipe[0].vld = ~rps_s;
      // Deselected port keeps a clean zero address
      st_next.rd_pipe[0].addr = rps_s ? '0 : addr_s;
      case (st_reg.wr_state)
        WR_IDLE, WR_BEAT1: begin
          if (!wps_s) begin
            st_next.wr_state = WR_BEAT1;
            st_next.wr_beat0 = d_s;
            st_next.wr_mask0 = mask_s;
          end else begin
            st_next.wr_state = WR_IDLE;
          end
        end
        default: begin
          st_next.wr_state = WR_IDLE;
        end
      endcase
    end
    if (kb_rise) begin
      if (st_reg.beat1_pend) begin
        st_next.q          = st_reg.q_beat1;
        st_next.beat1_pend = 1'b0;
      end
      case (st_reg.wr_state)
        WR_BEAT1: begin
          st_next.wr_state = WR_IDLE;
        end
        WR_IDLE: begin
          st_next.wr_state = WR_IDLE;
        end
        default: begin
          st_next.wr_state = WR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign read_data_out     = st_reg.q;
  assign read_data_oe      = st_reg.q_oe;
  assign read_output_valid = st_reg.q_vld;
  assign echo_timing_out   = st_reg.echo;
  assign echo_timing_out_n = st_reg.echo_n;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  AST_OE_RISES_ON_TRUE_EDGE: assert property (
    $rose(read_data_oe) |-> $past(k_rise)
  ) else $error("Read output enabled off a true clock rise");

  AST_LATENCY_TWO: assert property (
    (k_rise && dll_s && st_reg.rd_pipe[1].vld)
      |=> read_data_oe && read_output_valid
          && (read_data_out == $past(rd_word0))
  ) else $error("Two cycle read launch wrong");

  AST_LATENCY_ONE: assert property (
    (k_rise && !dll_s && st_reg.rd_pipe[0].vld)
      |=> read_data_oe && (read_data_out == $past(rd_word0))
  ) else $error("One cycle read launch wrong");

  AST_FLOAT_AFTER_DESELECT: assert property (
    (k_rise && !launch.vld) |=> !read_data_oe [*2]
  ) else $error("Read outputs driven with nothing pending");

  AST_SECOND_BEAT: assert property (
    (kb_rise && st_reg.beat1_pend)
      |=> read_data_oe && (read_data_out == $past(st_reg.q_beat1))
  ) else $error("Second read beat not launched on complement rise");

  AST_VALID_ECHO_ALIGNED: assert property (
    $changed(read_output_valid) |-> $changed(echo_timing_out)
  ) else $error("Valid flag moved off an echo clock edge");

  AST_VALID_MATCHES_DRIVE: assert property (
    read_output_valid == read_data_oe
  ) else $error("Valid flag and output drive disagree");

  AST_WRITE_START: assert property (
    (k_rise && !wps_s)
      |=> (st_reg.wr_state == WR_BEAT1) && (st_reg.wr_beat0 == $past(d_s))
  ) else $error("Write not started on low write select");

  // Idle spans the whole cycle, so no complement write can follow
  AST_NO_WRITE_DESELECTED: assert property (
    (k_rise && wps_s) |=> st_reg.wr_state == WR_IDLE
  ) else $error("Array written while write port deselected");

  AST_READ_ADDR_CAPTURED: assert property (
    (k_rise && !rps_s) |=> st_reg.rd_pipe[0].addr == $past(addr_s)
  ) else $error("Read address not taken on true clock rise");

  AST_ECHO_FOLLOWS_CLOCK: assert property (
    k_rise |=> echo_timing_out
  ) else $error("Echo clock did not follow the input clock");

  // Write side: capture at true rise, land at complement rise
  AST_MASK0_CAPTURE: assert property (
    (k_rise && !wps_s)
      |=> st_reg.wr_mask0 == $past(mask_s)
  ) else $error("First beat mask not taken on true clock rise");

  AST_DESELECT_KEEPS_BEAT0: assert property (
    (k_rise && wps_s)
      |=> $stable(st_reg.wr_beat0) && $stable(st_reg.wr_mask0)
  ) else $error("Write data taken while write port deselected");

  AST_WRITE_ENDS_AFTER_TWO: assert property (
    (kb_rise && (st_reg.wr_state == WR_BEAT1))
      |=> st_reg.wr_state == WR_IDLE
  ) else $error("Write burst did not end after two beats");

  AST_ONE_WRITE_PER_ACCESS: assert property (
    mem_wr_en
      |=> !mem_wr_en [*4]
  ) else $error("Array written twice for one access");

  AST_WRITE_WAITS_FOR_COMPLEMENT: assert property (
    (k_rise && !wps_s)
      |=> !mem_wr_en
  ) else $error("Array written before the complement clock rise");

  AST_WRITE_IDLE_HOLDS: assert property (
    (!k_rise && (st_reg.wr_state == WR_IDLE))
      |=> st_reg.wr_state == WR_IDLE
  ) else $error("Write started away from a true clock rise");

  // Nothing starts on a complement rise
  AST_NO_LAUNCH_ON_COMPLEMENT: assert property (
    kb_rise
      |=> $stable(read_data_oe) && $stable(read_output_valid)
  ) else $error("Read output enable moved on a complement rise");

  AST_NO_READ_START_ON_COMPLEMENT: assert property (
    kb_rise
      |=> $stable(st_reg.rd_pipe)
  ) else $error("Read queued on a complement rise");

  AST_NO_WRITE_START_ON_COMPLEMENT: assert property (
    (kb_rise && (st_reg.wr_state == WR_IDLE))
      |=> st_reg.wr_state == WR_IDLE
  ) else $error("Write started on a complement rise");

  AST_DATA_MOVES_ON_EDGES: assert property (
    $changed(read_data_out)
      |-> $past(k_rise) || $past(kb_rise)
  ) else $error("Read data changed away from an input clock rise");

  AST_BEAT0_STANDS: assert property (
    (kb_rise && !st_reg.beat1_pend)
      |=> $stable(read_data_out)
  ) else $error("Read data moved with no second beat pending");

  // Read pipeline and launch
  AST_READ_SELECT_QUEUED: assert property (
    (k_rise && !rps_s)
      |=> st_reg.rd_pipe[0].vld
  ) else $error("Read not queued on low read select");

  AST_READ_DESELECT_IGNORED: assert property (
    (k_rise && rps_s)
      |=> !st_reg.rd_pipe[0].vld && (st_reg.rd_pipe[0].addr == '0)
  ) else $error("Read address taken while read port deselected");

  AST_PIPE_ADVANCES: assert property (
    k_rise
      |=> st_reg.rd_pipe[1] == $past(st_reg.rd_pipe[0])
  ) else $error("Read pipeline did not advance on true rise");

  AST_LATENCY_TWO_NOT_EARLY: assert property (
    (k_rise && dll_s && !st_reg.rd_pipe[1].vld)
      |=> !read_data_oe
  ) else $error("Read data driven before two cycles");

  AST_LATENCY_ONE_NOT_EARLY: assert property (
    (k_rise && !dll_s && !st_reg.rd_pipe[0].vld)
      |=> !read_data_oe
  ) else $error("Read data driven with no read one cycle back");

  AST_BEAT1_FROM_BANK1: assert property (
    (k_rise && launch.vld)
      |=> st_reg.beat1_pend && (st_reg.q_beat1 == $past(rd_word1))
  ) else $error("Second beat not taken from the second bank");

  AST_BEAT1_ONCE: assert property (
    (kb_rise && st_reg.beat1_pend)
      |=> !st_reg.beat1_pend
  ) else $error("Read burst longer than two beats");

  AST_PENDING_READ_COMPLETES: assert property (
    (k_rise && launch.vld && rps_s)
      |=> read_data_oe && read_output_valid
  ) else $error("Pending read dropped on read deselect");

  AST_NO_LAUNCH_QUIET: assert property (
    (k_rise && !launch.vld)
      |=> !read_output_valid && !st_reg.beat1_pend
  ) else $error("Valid or second beat left with no read pending");

  AST_OE_FALLS_ON_TRUE_EDGE: assert property (
    $fell(read_data_oe)
      |-> $past(k_rise)
  ) else $error("Read outputs floated off a true clock rise");

  // Valid and echo move together on the true rise
  AST_VALID_RISES_ON_TRUE_EDGE: assert property (
    $rose(read_output_valid)
      |-> $past(k_rise) && $rose(echo_timing_out)
  ) else $error("Valid flag rose off an echo clock rise");

  AST_VALID_FALLS_ON_TRUE_EDGE: assert property (
    $fell(read_output_valid)
      |-> $past(k_rise) && $rose(echo_timing_out)
  ) else $error("Valid flag fell off an echo clock rise");

  AST_ECHO_TRACKS_CLOCK: assert property (
    echo_timing_out == $past(k_s)
  ) else $error("Echo clock lost track of the input clock");

  AST_ECHO_N_TRACKS_CLOCK: assert property (
    echo_timing_out_n == $past(kb_s)
  ) else $error("Complement echo lost track of its input clock");
endmodule : ddr_sram_dual_port_pins
`default_nettype wire

// ===== common/ddr_pins_map.svh
// Purpose: Widths, depths and latency counts of the dual port DDR SRAM
// Assumes: Wide variant, 36-bit words on a 20-bit address
// Notes:   Definitions only
`ifndef DDR_PINS_MAP_SVH
`define DDR_PINS_MAP_SVH
`define DATA_W       36
`define ADDR_W       20
`define LANES        4
`define LANE_W       9
`define PIN_W        65
`define MEM_WORDS    1048576
`define RD_LAT_DLL   2
`define RD_LAT_NODLL 1
`endif

// ===== common/ddr_pins_pkg.sv
// Purpose: Shared types and the byte lane decode
// Assumes: ddr_pins_map.svh gives widths
// Notes:   Lane i covers bits [9i+8:9i]
`include "ddr_pins_map.svh"
package ddr_pins_pkg;
  typedef logic [`DATA_W-1:0] word_t;
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`LANES-1:0]  mask_t;

  typedef enum logic {
    WR_IDLE  = 1'b0,
    WR_BEAT1 = 1'b1
  } wr_state_t;

  typedef struct packed {
    logic  vld;
    addr_t addr;
  } rd_slot_t;

  typedef struct packed {
    logic              k_prev;
    logic              kb_prev;
    wr_state_t         wr_state;
    word_t             wr_beat0;
    mask_t             wr_mask0;
    rd_slot_t [1:0]    rd_pipe;
    word_t             q_beat1;
    logic              beat1_pend;
    word_t             q;
    logic              q_oe;
    logic              q_vld;
    logic              echo;
    logic              echo_n;
  } core_t;

  // Active low lane mask to a per-bit write enable
  function automatic word_t lane_bits(input mask_t mask_n);
    word_t bits;
    bits = '0;
    for (int i = 0; i < `LANES; i++) begin
      bits[i*`LANE_W +: `LANE_W] = {`LANE_W{~mask_n[i]}};
    end
    return bits;
  endfunction : lane_bits
endpackage : ddr_pins_pkg

// ===== src/pin_sync.sv
// Purpose: Two flip-flop synchroniser for a bundle of pins
// Assumes: Pins are slow against mclk
// Notes:   First stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pins,
  output var  logic [W-1:0] synced
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_t;

  sync_t st_reg;
  sync_t st_next;

  always_comb begin
    st_next        = st_reg;
    st_next.meta   = pins;
    st_next.stable = st_reg.meta;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign synced = st_reg.stable;
endmodule : pin_sync
`default_nettype wire

// ===== src/sram_lane_store.sv
// Purpose: Two equal banks holding the two words of each access
// Assumes: One write per call, both words at one address
// Notes:   Read is combinational so a launch sees the newest data
`timescale 1ns/10ps
`default_nettype none
`include "ddr_pins_map.svh"
module sram_lane_store
  import ddr_pins_pkg::*;
(
  input  wire logic  mclk,
  input  wire logic  rst_n,
  input  wire logic  wr_en,
  input  wire addr_t wr_addr,
  input  wire word_t wr_word0,
  input  wire word_t wr_bits0,
  input  wire word_t wr_word1,
  input  wire word_t wr_bits1,
  input  wire addr_t rd_addr,
  output var  word_t rd_word0,
  output var  word_t rd_word1
);
  // No reset: contents are undefined at power up
  word_t bank0 [0:`MEM_WORDS-1];
  word_t bank1 [0:`MEM_WORDS-1];
  word_t old0;
  word_t old1;

  assign old0 = bank0[wr_addr];
  assign old1 = bank1[wr_addr];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      bank0[wr_addr] <= (bank0[wr_addr] & ~wr_bits0) | (wr_word0 & wr_bits0);
      bank1[wr_addr] <= (bank1[wr_addr] & ~wr_bits1) | (wr_word1 & wr_bits1);
    end
  end

  assign rd_word0 = bank0[rd_addr];
  assign rd_word1 = bank1[rd_addr];

  AST_MASKED_LANE_KEPT: assert property (
    @(posedge mclk) disable iff (!rst_n)
    wr_en |=> ((bank0[$past(wr_addr)] ^ $past(old0)) & ~$past(wr_bits0)) == '0
  ) else $error("Masked lane of word 0 changed");

  AST_MASKED_LANE_KEPT_B1: assert property (
    @(posedge mclk) disable iff (!rst_n)
    wr_en
      |=> ((bank1[$past(wr_addr)] ^ $past(old1)) & ~$past(wr_bits1)) == '0
  ) else $error("Masked lane of word 1 changed");

  AST_ENABLED_LANE_WRITTEN: assert property (
    @(posedge mclk) disable iff (!rst_n)
    wr_en
      |=> ((bank0[$past(wr_addr)] ^ $past(wr_word0))
           & $past(wr_bits0)) == '0
  ) else $error("Enabled lane of word 0 not written");
endmodule : sram_lane_store
`default_nettype wire

// ===== testbench/ctrl_model.sv
// Purpose: Memory controller model driving the SRAM pins
// Assumes: cycle is entered in the low half of tclk
// Notes:   Unselected address and data lines get inverted values, not stale ones
`timescale 1ns/10ps
`default_nettype none
module ctrl_model
  import ddr_pins_pkg::*;
(
  input  wire logic  mclk,
  input  wire word_t q,
  input  wire logic  oe,
  input  wire logic  vld,
  input  wire logic  echo,
  input  wire logic  echo_n,
  output var  logic  tclk,
  output var  logic  cclk,
  output var  logic  rs_n,
  output var  logic  ws_n,
  output var  mask_t m_n,
  output var  addr_t a,
  output var  word_t d
);
  logic  s_oe0, s_vld0, s_e0, s_oe1, s_en1;
  word_t s_q0, s_q1;
  initial begin
    {rs_n, ws_n, m_n, a, d} = '1;
    tclk = 1'b0;
    #100;
    forever #62.5 tclk = ~tclk;
  end
  always_comb cclk = ~tclk;
  // Mid half period, well clear of both pin edges
  task automatic half;
    repeat (8) @(posedge mclk);
    #1;
  endtask : half
  // Selects only for the true rise, two beats per access
  task automatic cycle(input logic r, w, input addr_t ra, wa,
                       input word_t d0, d1, input mask_t m0, m1);
    rs_n = r;
    ws_n = w;
    a    = r ? ~a : ra;
    d    = w ? ~d : d0;
    m_n  = m0;
    @(posedge tclk);
    half();
    {s_oe0, s_vld0, s_e0, s_q0} = {oe, vld, echo, q};
    a    = w ? ~a : wa;
    d    = w ? ~d : d1;
    m_n  = m1;
    @(negedge tclk);
    half();
    {s_oe1, s_en1, s_q1} = {oe, echo_n, q};
  endtask : cycle
endmodule : ctrl_model
`default_nettype wire

// ===== testbench/ddr_sram_dual_port_pins_test.sv
// Purpose: Self-checking bench for the SRAM pin block
// Assumes: Delay loop on unless a test turns it off
// Notes:   Only written addresses are read back
`timescale 1ns/10ps
`default_nettype none
module ddr_sram_dual_port_pins_test
  import ddr_pins_pkg::*;
;
  logic  mclk, rst_n, dl_n, tclk, cclk, rs_n, ws_n;
  logic  oe, vld, eo, eo_n;
  mask_t m_n;
  addr_t a;
  word_t d, q;
  int    fails, samples_checked;
  ddr_sram_dual_port_pins ddr_sram_dual_port_pins_i (
    .mclk(mclk), .rst_n(rst_n), .in_clk(tclk), .in_clk_n(cclk),
    .read_port_select_n(rs_n), .write_port_select_n(ws_n),
    .byte_lane_write_mask_n(m_n), .addr(a), .write_data(d),
    .delay_loop_disable_n(dl_n), .read_data_out(q),
    .read_data_oe(oe), .read_output_valid(vld),
    .echo_timing_out(eo), .echo_timing_out_n(eo_n));
  ctrl_model c (.mclk(mclk), .q(q), .oe(oe), .vld(vld), .echo(eo),
    .echo_n(eo_n), .tclk(tclk), .cclk(cclk), .rs_n(rs_n),
    .ws_n(ws_n), .m_n(m_n), .a(a), .d(d));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic idle;
    c.cycle(1'b1, 1'b1, '0, '0, '0, '0, '1, '1);
  endtask : idle
  task automatic wr(input addr_t wa, input word_t d0, d1,
                    input mask_t m0, m1);
    c.cycle(1'b1, 1'b0, '0, wa, d0, d1, m0, m1);
  endtask : wr
  task automatic rd(input addr_t ra, input int lat, input word_t e0, e1);
    c.cycle(1'b0, 1'b1, ra, '0, '0, '0, '1, '1);
    for (int i = 1; i <= lat; i++) begin
      idle();
      if (i < lat) chk(c.s_oe0 === 1'b0, "data early");
    end
    chk(c.s_oe0 === 1'b1 && c.s_vld0 === 1'b1, "not valid");
    chk(c.s_q0 === e0 && c.s_q1 === e1, "read data");
    chk(c.s_oe1 === 1'b1, "beat1 floated");
    idle();
    chk(c.s_oe0 === 1'b0 && c.s_vld0 === 1'b0, "not floated");
  endtask : rd
  task automatic t_basic;
    chk(oe === 1'b0 && vld === 1'b0, "driven at start");
    wr(20'h00005, 36'h123456789, 36'hfedcba987, '0, '0);
    rd(20'h00005, 2, 36'h123456789, 36'hfedcba987);
    chk(c.s_e0 === 1'b1 && c.s_en1 === 1'b1, "echo");
  endtask : t_basic
  task automatic t_concurrent;
    c.cycle(1'b0, 1'b0, 20'h00005, 20'h0000a, 36'h0aaaaaaaa,
            36'h055555555, '0, '0);
    c.cycle(1'b0, 1'b1, 20'h0000a, '0, '0, '0, '1, '1);
    idle();
    chk(c.s_q0 === 36'h123456789 && c.s_q1 === 36'hfedcba987,
        "first burst");
    idle();
    chk(c.s_oe0 === 1'b1 && c.s_q0 === 36'h0aaaaaaaa &&
        c.s_q1 === 36'h055555555, "second burst");
    idle();
    idle();
  endtask : t_concurrent
  task automatic t_masks;
    word_t e0, e1;
    for (int i = 0; i < 4; i++) begin
      e0 = '1;
      e1 = '1;
      e0[i*9 +: 9] = 9'h000;
      e1[(3-i)*9 +: 9] = 9'h000;
      wr(20'h00003, '1, '1, '0, '0);
      wr(20'h00003, '0, '0, mask_t'(~(4'h1 << i)),
         mask_t'(~(4'h8 >> i)));
      rd(20'h00003, 2, e0, e1);
    end
  endtask : t_masks
  task automatic t_desel;
    wr(20'h00003, '1, '1, '0, '0);
    c.cycle(1'b1, 1'b1, 20'h00003, 20'h00003, '0, '0, '0, '0);
    rd(20'h00003, 2, '1, '1);
  endtask : t_desel
  task automatic t_dll_off;
    dl_n = 1'b0;
    idle();
    idle();
    rd(20'h0000a, 1, 36'h0aaaaaaaa, 36'h055555555);
    dl_n = 1'b1;
    idle();
    idle();
  endtask : t_dll_off
  task automatic test_done;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // Catches a stalled input clock as well as a hung task
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    test_done();
  end
  initial begin
    fails = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    dl_n = 1'b1;
    repeat (4) @(posedge mclk);
    #1 rst_n = 1'b1;
    @(negedge tclk);
    c.half();
    t_basic();
    t_concurrent();
    t_masks();
    t_desel();
    t_dll_off();
    test_done();
  end
endmodule : ddr_sram_dual_port_pins_test
`default_nettype wire
